// file: logic/csf_status_bank.sv
`timescale 1ns/100ps
`include "csf_consts.svh"


module csf_status_bank #(
	parameter logic [6:0] DEV_ADDR = 7'h10 // Arbitrary bus address
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output      logic              sda_out,
	output      logic              sda_oe,
	input  wire csf_pkg::csf_src_s src,
	input  wire logic              int_repeat_sel,
	output      logic              int_repeat_hold
);
	import csf_pkg::*;

	if (DEV_ADDR == 7'h00) begin : g_chk
		$error("csf_status_bank: address zero is the general call");
	end

	// True when an offset lies within an inclusive range
	function automatic logic csf_hit(
		input logic [7:0] ofs,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		csf_hit = (ofs >= lo) && (ofs <= hi);
	endfunction : csf_hit

	// Line edge and bus condition pulses
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Slave state and its next values
	csf_state_e  st_r;
	csf_state_e  st_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic [7:0]  sh_r;
	logic [7:0]  sh_nxt;
	logic [7:0]  ptr_r;
	logic [7:0]  ptr_nxt;
	logic        oe_r;
	logic        oe_nxt;
	logic        rw_r;
	logic        rw_nxt;
	logic        first_r;
	logic        first_nxt;
	logic        nack_r;
	logic        nack_nxt;
	logic        load_tx;
	logic        wr_en;

	// Flag state
	logic [3:0]  ovf_set;
	logic [3:0]  ovf_q;
	logic [5:0]  pb_set;
	logic [5:0]  pb_q;
	logic [3:0]  rec_set;
	logic [3:0]  rec_q;
	logic [5:0]  live_r;
	logic        hs_prev_r;
	logic        hs_change;
	logic [7:0]  ovf_wr_r;
	logic [7:0]  rec_wr_r;
	logic [7:0]  rsv_mem [0:3];

	// Read side
	logic        rd_ovf;
	logic        rd_pb;
	logic        rd_rec;
	logic [7:0]  ovf_byte;
	logic [7:0]  pb_byte;
	logic [7:0]  rec_byte;
	logic [7:0]  live_byte;
	logic [7:0]  tx_byte;

	// Repeat pulsing bookkeeping
	logic        ev_pb_rec;
	logic        seen_pb_r;
	logic        seen_rec_r;
	logic        seen_pb_nxt;
	logic        seen_rec_nxt;
	logic        pend_r;
	logic        pend_nxt;

	csf_line_edge u_edge (
		.clk       (clk),
		.nrst      (nrst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// Event sources for each latched register
	assign ovf_set = {src.dac_ovf, src.dac_shift_ovf,
		src.adc_ovf, src.adc_shift_ovf};
	assign hs_change = src.headset_in ^ hs_prev_r;
	assign pb_set  = {src.short_det, src.button, hs_change,
		src.compressor_above, src.dac_eng_std,
		src.dac_eng_aux};
	assign rec_set = {src.gain_noise_below, src.adc_eng_std,
		src.adc_eng_aux, src.dc_meas_rdy};

	// Clear on read when a byte is loaded for sending
	assign rd_ovf = load_tx && (ptr_r == `CSF_OFS_OVF);
	assign rd_pb  = load_tx && (ptr_r == `CSF_OFS_PB_LAT);
	assign rd_rec = load_tx && (ptr_r == `CSF_OFS_REC);

	csf_sticky #(.W(4)) u_ovf (
		.clk  (clk),
		.nrst (nrst),
		.set  (ovf_set),
		.clr  (rd_ovf),
		.q    (ovf_q)
	);

	csf_sticky #(.W(6)) u_pb (
		.clk  (clk),
		.nrst (nrst),
		.set  (pb_set),
		.clr  (rd_pb),
		.q    (pb_q)
	);

	csf_sticky #(.W(4)) u_rec (
		.clk  (clk),
		.nrst (nrst),
		.set  (rec_set),
		.clr  (rd_rec),
		.q    (rec_q)
	);

	// Live playback view and headset history
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			live_r    <= '0;
			hs_prev_r <= 1'b0;
		end else begin
			live_r    <= {pb_set[5:4], src.headset_in,
				pb_set[2:0]};
			hs_prev_r <= src.headset_in;
		end
	end

	// Overflow register view; bits 6 and 4 stay zero
	always_comb begin
		ovf_byte = ovf_wr_r;
		ovf_byte[`CSF_OVF_DAC_BIT] = ovf_q[3];
		ovf_byte[`CSF_OVF_DSH_BIT] = ovf_q[2];
		ovf_byte[`CSF_OVF_ADC_BIT] = ovf_q[1];
		ovf_byte[`CSF_OVF_ASH_BIT] = ovf_q[0];
	end

	// Latched playback view
	always_comb begin
		pb_byte = `CSF_RST_BYTE;
		pb_byte[`CSF_PB_SHORT_BIT] = pb_q[5];
		pb_byte[`CSF_PB_BTN_BIT]   = pb_q[4];
		pb_byte[`CSF_PB_HS_BIT]    = pb_q[3];
		pb_byte[`CSF_PB_CMP_BIT]   = pb_q[2];
		pb_byte[`CSF_PB_STD_BIT]   = pb_q[1];
		pb_byte[`CSF_PB_AUX_BIT]   = pb_q[0];
	end

	// Record view with stored reserved writable bits
	always_comb begin
		rec_byte = rec_wr_r;
		rec_byte[`CSF_REC_NOISE_BIT] = rec_q[3];
		rec_byte[`CSF_REC_STD_BIT]   = rec_q[2];
		rec_byte[`CSF_REC_AUX_BIT]   = rec_q[1];
		rec_byte[`CSF_REC_DC_BIT]    = rec_q[0];
	end

	// Live playback view
	always_comb begin
		live_byte = `CSF_RST_BYTE;
		live_byte[`CSF_PB_SHORT_BIT] = live_r[5];
		live_byte[`CSF_PB_BTN_BIT]   = live_r[4];
		live_byte[`CSF_PB_HS_BIT]    = live_r[3];
		live_byte[`CSF_PB_CMP_BIT]   = live_r[2];
		live_byte[`CSF_PB_STD_BIT]   = live_r[1];
		live_byte[`CSF_PB_AUX_BIT]   = live_r[0];
	end

	// Byte sent for the current pointer; unmapped offsets read zero
	assign tx_byte =
		(ptr_r == `CSF_OFS_OVF)     ? ovf_byte  :
		(ptr_r == `CSF_OFS_PB_LAT)  ? pb_byte   :
		(ptr_r == `CSF_OFS_REC)     ? rec_byte  :
		(ptr_r == `CSF_OFS_PB_LIVE) ? live_byte :
		csf_hit(ptr_r, `CSF_OFS_RSV_LO, `CSF_OFS_RSV_HI) ?
			rsv_mem[ptr_r[1:0]] : `CSF_RST_BYTE;

	// Host writes: reserved bits within the write masks, and the whole reserved range, are stored and read back as written
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ovf_wr_r <= `CSF_RST_BYTE;
			rec_wr_r <= `CSF_RST_BYTE;
			for (int i = 0; i < 4; i++) begin
				rsv_mem[i] <= `CSF_RST_BYTE;
			end
		end else if (wr_en) begin
			if (ptr_r == `CSF_OFS_OVF) begin
				ovf_wr_r <= sh_r & `CSF_OVF_WMASK;
			end
			if (ptr_r == `CSF_OFS_REC) begin
				rec_wr_r <= sh_r & `CSF_REC_WMASK;
			end
			if (csf_hit(ptr_r, `CSF_OFS_RSV_LO, `CSF_OFS_RSV_HI)) begin
				rsv_mem[ptr_r[1:0]] <= sh_r;
			end
		end
	end

	// Serial slave: receive on rising clock, drive on falling clock
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		ptr_nxt   = ptr_r;
		oe_nxt    = oe_r;
		rw_nxt    = rw_r;
		first_nxt = first_r;
		nack_nxt  = nack_r;
		load_tx   = 1'b0;
		wr_en     = 1'b0;
		if (stop_det) begin
			st_nxt = CSF_ST_IDLE;
			oe_nxt = 1'b0;
		end else if (start_det) begin
			st_nxt  = CSF_ST_ADDR;
			cnt_nxt = `CSF_RST_CNT;
			oe_nxt  = 1'b0;
		end else begin
			unique case (st_r)
				CSF_ST_IDLE: begin
				end
				CSF_ST_ADDR: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], sda_in};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `CSF_BITS_BYTE) begin
						if (sh_r[7:1] == DEV_ADDR) begin
							oe_nxt = 1'b1;
							rw_nxt = sh_r[0];
							st_nxt = CSF_ST_ACKA;
						end else begin
							st_nxt = CSF_ST_IDLE;
						end
					end
				end
				CSF_ST_ACKA: begin
					if (scl_fall && rw_r) begin
						load_tx = 1'b1;
						sh_nxt  = tx_byte;
						oe_nxt  = ~tx_byte[7];
						cnt_nxt = `CSF_RST_CNT;
						ptr_nxt = ptr_r + 8'h01;
						st_nxt  = CSF_ST_TX;
					end else if (scl_fall) begin
						oe_nxt    = 1'b0;
						first_nxt = 1'b1;
						cnt_nxt   = `CSF_RST_CNT;
						st_nxt    = CSF_ST_RX;
					end
				end
				CSF_ST_RX: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], sda_in};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `CSF_BITS_BYTE) begin
						oe_nxt = 1'b1;
						st_nxt = CSF_ST_ACKW;
						if (first_r) begin
							ptr_nxt   = sh_r;
							first_nxt = 1'b0;
						end else begin
							wr_en   = 1'b1;
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				CSF_ST_ACKW: begin
					if (scl_fall) begin
						oe_nxt  = 1'b0;
						cnt_nxt = `CSF_RST_CNT;
						st_nxt  = CSF_ST_RX;
					end
				end
				CSF_ST_TX: begin
					if (scl_fall && cnt_r == `CSF_LAST_TX_BIT) begin
						oe_nxt = 1'b0;
						st_nxt = CSF_ST_ACKR;
					end else if (scl_fall) begin
						sh_nxt  = {sh_r[6:0], 1'b0};
						oe_nxt  = ~sh_r[6];
						cnt_nxt = cnt_r + 4'h1;
					end
				end
				CSF_ST_ACKR: begin
					if (scl_rise) begin
						nack_nxt = sda_in;
					end else if (scl_fall && nack_r) begin
						st_nxt = CSF_ST_IDLE;
					end else if (scl_fall) begin
						load_tx = 1'b1;
						sh_nxt  = tx_byte;
						oe_nxt  = ~tx_byte[7];
						cnt_nxt = `CSF_RST_CNT;
						ptr_nxt = ptr_r + 8'h01;
						st_nxt  = CSF_ST_TX;
					end
				end
				default: begin
					st_nxt = CSF_ST_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	// Serial slave registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r    <= CSF_ST_IDLE;
			cnt_r   <= `CSF_RST_CNT;
			sh_r    <= `CSF_RST_BYTE;
			ptr_r   <= `CSF_RST_BYTE;
			oe_r    <= 1'b0;
			rw_r    <= 1'b0;
			first_r <= 1'b0;
			nack_r  <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= ptr_nxt;
			oe_r    <= oe_nxt;
			rw_r    <= rw_nxt;
			first_r <= first_nxt;
			nack_r  <= nack_nxt;
		end
	end

	// Pending until the latched playback and record registers both read since the last event of either
	assign ev_pb_rec    = |pb_set | |rec_set;
	assign seen_pb_nxt  = ~ev_pb_rec & (seen_pb_r | rd_pb);
	assign seen_rec_nxt = ~ev_pb_rec & (seen_rec_r | rd_rec);
	assign pend_nxt     = ev_pb_rec | (pend_r &
		~((seen_pb_r | rd_pb) & (seen_rec_r | rd_rec)));

	// Repeat bookkeeping and pin-facing outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seen_pb_r       <= 1'b0;
			seen_rec_r      <= 1'b0;
			pend_r          <= 1'b0;
			int_repeat_hold <= 1'b0;
			sda_oe          <= 1'b0;
			sda_out         <= 1'b0;
		end else begin
			seen_pb_r       <= seen_pb_nxt;
			seen_rec_r      <= seen_rec_nxt;
			pend_r          <= pend_nxt;
			int_repeat_hold <= pend_nxt & int_repeat_sel;
			sda_oe          <= oe_nxt;
			sda_out         <= 1'b0; // Open drain: only ever pulls low
		end
	end

endmodule : csf_status_bank

// file: logic/csf_consts.svh
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// Register offsets on the serial control port, page 0
`define CSF_OFS_OVF      8'h27
`define CSF_OFS_RSV_LO   8'h28
`define CSF_OFS_RSV_HI   8'h2b
`define CSF_OFS_PB_LAT   8'h2c
`define CSF_OFS_REC      8'h2d
`define CSF_OFS_PB_LIVE  8'h2e

// Overflow register field positions and writable reserved mask
`define CSF_OVF_DAC_BIT  7
`define CSF_OVF_DSH_BIT  5
`define CSF_OVF_ADC_BIT  3
`define CSF_OVF_ASH_BIT  1
`define CSF_OVF_WMASK    8'h05

// Playback flag field positions, shared by latched and live views
`define CSF_PB_SHORT_BIT 7
`define CSF_PB_BTN_BIT   5
`define CSF_PB_HS_BIT    4
`define CSF_PB_CMP_BIT   3
`define CSF_PB_STD_BIT   1
`define CSF_PB_AUX_BIT   0

// Record flag field positions and writable reserved mask
`define CSF_REC_NOISE_BIT 6
`define CSF_REC_STD_BIT   4
`define CSF_REC_AUX_BIT   3
`define CSF_REC_DC_BIT    2
`define CSF_REC_WMASK     8'h83

// Reset values
`define CSF_RST_BYTE     8'h00
`define CSF_RST_CNT      4'h0

// Serial transfer constants
`define CSF_BITS_BYTE    4'h8
`define CSF_LAST_TX_BIT  4'h7

`endif

// file: logic/csf_pkg.sv
package csf_pkg;

	// Flag sources from the codec datapaths and detectors
	typedef struct packed {
		logic dac_ovf;
		logic dac_shift_ovf;
		logic adc_ovf;
		logic adc_shift_ovf;
		logic short_det;
		logic button;
		logic headset_in;
		logic compressor_above;
		logic gain_noise_below;
		logic dac_eng_std;
		logic dac_eng_aux;
		logic adc_eng_std;
		logic adc_eng_aux;
		logic dc_meas_rdy;
	} csf_src_s;

	// Serial slave states
	typedef enum logic [6:0] {
		CSF_ST_IDLE = 7'b0000001,
		CSF_ST_ADDR = 7'b0000010,
		CSF_ST_ACKA = 7'b0000100,
		CSF_ST_RX   = 7'b0001000,
		CSF_ST_ACKW = 7'b0010000,
		CSF_ST_TX   = 7'b0100000,
		CSF_ST_ACKR = 7'b1000000
	} csf_state_e;

endpackage : csf_pkg

// file: logic/csf_sticky.sv
`timescale 1ns/100ps

module csf_sticky #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] set,
	input  wire logic         clr,
	output      logic [W-1:0] q
);
	logic [W-1:0] q_nxt;

	if (W < 1) begin : g_chk
		$error("csf_sticky: width must be at least one");
	end

	// A set in the clearing cycle survives the clear
	assign q_nxt = set | (q & ~{W{clr}});

	// Flag storage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= q_nxt;
		end
	end

endmodule : csf_sticky

// file: logic/csf_line_edge.sv
`timescale 1ns/100ps

module csf_line_edge (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output      logic scl_rise,
	output      logic scl_fall,
	output      logic start_det,
	output      logic stop_det
);
	logic scl_r;
	logic sda_r;

	// Previous line levels; an idle bus sits high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			scl_r <= scl_in;
			sda_r <= sda_in;
		end
	end

	// Clock edges, and data edges while the clock stays high
	assign scl_rise  = scl_in & ~scl_r;
	assign scl_fall  = ~scl_in & scl_r;
	assign start_det = scl_in & scl_r & sda_r & ~sda_in;
	assign stop_det  = scl_in & scl_r & ~sda_r & sda_in;

endmodule : csf_line_edge

// file: sim/csf_bank_monitor.sv
`timescale 1ns/100ps

// Port-level watch on the status bank and its serial control port
module csf_bank_monitor (
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              scl_in,
	input wire logic              sda_in,
	input wire logic              sda_out,
	input wire logic              sda_oe,
	input wire csf_pkg::csf_src_s src,
	input wire logic              int_repeat_sel,
	input wire logic              int_repeat_hold
);
	import csf_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// A playback or record event with repeat pulsing selected
	sequence pend_event;
		int_repeat_sel && (src.short_det || src.gain_noise_below);
	endsequence

	// Selection kept up while the hold is built
	sequence sel_kept;
		int_repeat_sel [*3];
	endsequence

	// Repeat hold behaviour
	chk_hold_after_event: assert property (
		pend_event ##1 sel_kept |-> int_repeat_hold)
		else $error("repeat hold missing after event");
	chk_hold_needs_sel: assert property (
		!int_repeat_sel |=> !int_repeat_hold)
		else $error("repeat hold without selection");
	chk_hold_drop_read: assert property (
		$fell(int_repeat_hold) |-> !$past(int_repeat_sel) || !scl_in)
		else $error("repeat hold dropped outside a read");
	chk_reset_quiet: assert property (
		$rose(nrst) |-> !sda_oe && !int_repeat_hold)
		else $error("outputs active after reset");

	// Serial port drive discipline
	chk_data_clock_low: assert property (
		$changed(sda_oe) |-> !scl_in)
		else $error("data drive changed with clock high");
	chk_drive_low_only: assert property (
		sda_oe |-> !sda_out)
		else $error("data line driven high");
	chk_free_after_stop: assert property (
		scl_in && $rose(sda_in) |-> !sda_oe ##1 !sda_oe)
		else $error("data driven after stop");
	chk_free_at_start: assert property (
		scl_in && $past(scl_in) && $fell(sda_in) |-> !sda_oe)
		else $error("data driven at start");
endmodule : csf_bank_monitor

bind csf_status_bank csf_bank_monitor u_csf_bank_monitor (
	.clk            (clk),
	.nrst           (nrst),
	.scl_in         (scl_in),
	.sda_in         (sda_in),
	.sda_out        (sda_out),
	.sda_oe         (sda_oe),
	.src            (src),
	.int_repeat_sel (int_repeat_sel),
	.int_repeat_hold(int_repeat_hold)
);

// file: sim/csf_host_model.sv
`timescale 1ns/100ps

// Host on the serial control port, pulling the data line low only
module csf_host_model (
	input  wire logic clk,
	input  wire logic sda,
	output      logic scl,
	output      logic sda_low
);
	// Both lines released outside frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Each line level stands four system clocks
	task automatic gap();
		repeat (4) @(posedge clk);
	endtask : gap

	// Start or repeated start: data falls while clock is high
	task automatic start();
		sda_low <= 1'b0;
		gap();
		scl <= 1'b1;
		gap();
		sda_low <= 1'b1;
		gap();
		scl <= 1'b0;
		gap();
	endtask : start

	// Stop: data rises while clock is high
	task automatic stop();
		sda_low <= 1'b1;
		gap();
		scl <= 1'b1;
		gap();
		sda_low <= 1'b0;
		gap();
	endtask : stop

	// One bit: data set with clock low, sampled with clock high
	task automatic bit_io(input logic b, output logic got);
		sda_low <= ~b;
		gap();
		scl <= 1'b1;
		gap();
		got = sda;
		scl <= 1'b0;
		gap();
	endtask : bit_io

	// Byte out MSB first; nak is the acknowledge bit seen
	task automatic send(input logic [7:0] d, output logic nak);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(d[i], g);
		bit_io(1'b1, nak);
	endtask : send

	// Byte in MSB first, then our acknowledge (last = refuse)
	task automatic recv(input logic last, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, g);
	endtask : recv
endmodule : csf_host_model

// file: sim/test_csf_status_bank.sv
`timescale 1ns/100ps

module test_csf_status_bank;
	import csf_pkg::*;

	localparam logic [6:0] ADDR = 7'h10; // Arbitrary bus address
	// Source bit 13 down to 0: offset and expected flag
	localparam logic [15:0] EV [14] = '{
		16'h2780, 16'h2720, 16'h2708,
		16'h2702, 16'h2c80, 16'h2c20,
		16'h2c10, 16'h2c08, 16'h2d40,
		16'h2c02, 16'h2c01, 16'h2d10,
		16'h2d08, 16'h2d04
	};

	logic     clk;
	logic     nrst;
	logic     scl;
	logic     host_low;
	logic     sda_out;
	logic     sda_oe;
	logic     sda;
	csf_src_s src;
	logic     rep_sel;
	logic     rep_hold;
	int       num_errors;
	int       comparisons;

	// Open-drain data line with pull-up
	assign sda = (sda_oe ? sda_out : 1'b1) & ~host_low;

	csf_status_bank #(
		.DEV_ADDR(ADDR)
	) u_csf_status_bank (
		.clk            (clk),
		.nrst           (nrst),
		.scl_in         (scl),
		.sda_in         (sda),
		.sda_out        (sda_out),
		.sda_oe         (sda_oe),
		.src            (src),
		.int_repeat_sel (rep_sel),
		.int_repeat_hold(rep_hold)
	);

	csf_host_model u_csf_host_model (
		.clk    (clk),
		.sda    (sda),
		.scl    (scl),
		.sda_low(host_low)
	);

	// System clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Compare one byte and count the outcome
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Read consecutive registers from ofs and compare each byte
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp [$]);
		logic       nak;
		logic [7:0] d;
		u_csf_host_model.start();
		u_csf_host_model.send({ADDR, 1'b0}, nak);
		u_csf_host_model.send(ofs, nak);
		u_csf_host_model.start();
		u_csf_host_model.send({ADDR, 1'b1}, nak);
		check("read acknowledge", 8'h00, {7'h00, nak});
		foreach (exp[i]) begin
			u_csf_host_model.recv(i == exp.size() - 1, d);
			check("read data", exp[i], d);
		end
		u_csf_host_model.stop();
	endtask : rd

	// Write one byte; a foreign address must be refused
	task automatic wr(input logic [6:0] adr, input logic [7:0] ofs,
		input logic [7:0] d);
		logic nak;
		u_csf_host_model.start();
		u_csf_host_model.send({adr, 1'b0}, nak);
		check("address acknowledge", {7'h00, adr != ADDR}, {7'h00, nak});
		u_csf_host_model.send(ofs, nak);
		u_csf_host_model.send(d, nak);
		u_csf_host_model.stop();
	endtask : wr

	// Print counts and verdict, then end the run
	task automatic test_done();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// Pulse the given sources for a single clock
	task automatic pulse(input logic [13:0] s);
		src <= csf_src_s'(s);
		@(posedge clk);
		src <= '0;
		repeat (4) @(posedge clk);
	endtask : pulse

	// Main sequence
	initial begin
		nrst <= 1'b0;
		src <= '0;
		rep_sel <= 1'b0;
		num_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h27, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00});
		// Each source latches its own flag; a read clears it
		for (int i = 0; i < 14; i++) begin
			pulse(14'h2000 >> i);
			rd(EV[i][15:8], '{EV[i][7:0]});
			rd(EV[i][15:8], '{8'h00});
		end
		// Held levels: live view follows without clearing
		src <= csf_src_s'(14'h03d8);
		repeat (3) @(posedge clk);
		rd(8'h2e, '{8'hbb});
		rd(8'h2e, '{8'hbb});
		src <= '0;
		repeat (3) @(posedge clk);
		rd(8'h2e, '{8'h00});
		rd(8'h2c, '{8'hbb, 8'h00, 8'h00});
		rd(8'h2c, '{8'h00});
		// Repeat hold until both latched playback and record registers are read
		rep_sel <= 1'b1;
		pulse(14'h0220);
		check("repeat hold", 8'h01, {7'h00, rep_hold});
		rd(8'h2c, '{8'h80});
		check("repeat hold", 8'h01, {7'h00, rep_hold});
		rd(8'h2d, '{8'h40});
		repeat (3) @(posedge clk);
		check("repeat hold", 8'h00, {7'h00, rep_hold});
		rep_sel <= 1'b0;
		pulse(14'h0100);
		check("repeat hold", 8'h00, {7'h00, rep_hold});
		// Writes: zeros to reserved places, read-only ignored
		wr(ADDR, 8'h27, 8'h00);
		wr(ADDR, 8'h2d, 8'h00);
		wr(ADDR, 8'h28, 8'h00);
		wr(ADDR, 8'h2c, 8'hff);
		wr(7'h11, 8'h2e, 8'h00);
		rd(8'h27, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20,
			8'h00});
		// Reset in mid-run drops the hold and the latched short flag in the playback register
		rep_sel <= 1'b1;
		pulse(14'h0200);
		check("repeat hold", 8'h01, {7'h00, rep_hold});
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		check("repeat hold", 8'h00, {7'h00, rep_hold});
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h2c, '{8'h00});
		test_done();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		test_done();
	end
endmodule : test_csf_status_bank
